// ---- hdl/flr_pkg.sv ----
// Package for the fault-log block readout: record layout, loop layout, stream types.
// Assumes one 200 MHz clock and a synchronous active-high reset in every user.
package flr_pkg;
  localparam int unsigned FLR_CHANNELS = 8;
  localparam int unsigned FLR_LOOP_BYTES = 46;
  localparam int unsigned FLR_CHAN_BYTES = 5;
  localparam logic [7:0] FLR_REC_LAST = 8'hfe;
  localparam logic [7:0] FLR_REC_COUNT = 8'hff;
  localparam logic [7:0] FLR_INVALID_FIRST = 8'he8;
  localparam logic [7:0] FLR_INVALID_LAST = 8'hed;
  localparam logic [7:0] FLR_RESERVED_FIRST = 8'hee;
  localparam logic [7:0] FLR_RESERVED_VALUE = 8'h00;
  localparam logic [7:0] FLR_POS_FIRST = 8'h00;
  localparam logic [5:0] FLR_LOOP_LAST = 6'd45;
  localparam logic [2:0] FLR_CHAN_TOP = 3'd7;

  // Byte slot within one channel group, in stream order
  typedef enum logic [2:0] {
    FLR_SLOT_SECONDARY = 3'b000,
    FLR_SLOT_SPECIFIC = 3'b001,
    FLR_SLOT_OUTPUT = 3'b010,
    FLR_SLOT_VHIGH = 3'b011,
    FLR_SLOT_VLOW = 3'b100
  } flr_slot_t;

  typedef enum logic [1:0] {
    FLR_ST_IDLE = 2'b00,
    FLR_ST_STREAM = 2'b01,
    FLR_ST_DRAIN = 2'b10
  } flr_state_t;

  // One byte of the outgoing record
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] pos;
    logic invalid;
    logic last;
  } flr_beat_t;

  // Telemetry for one channel in one loop
  typedef struct packed {
    logic [7:0] secondary;
    logic [7:0] specific;
    logic [7:0] output_status;
    logic [15:0] reading;
  } flr_chan_t;
endpackage

// ---- hdl/flr_readout.sv ----
// Fault-log readout: streams a stored record, head and tail, 255 bytes, to the serial link.
// Assumes the link engine pulses start per block read and abort when the host stops early;
// telemetry words are held stable by the logging core for the whole read.
//
// Functional notes
// - Loop is 46 bytes, channels 7 down to 0
// - Positions 232 to 237 are flagged invalid
// - Positions 0xEE to 0xFE return zero
// - One 255-byte read, ascending order
// - Odd channels may report sense-resistor current
// - Shared timebase, fault and control lines coordinate peers
module flr_readout #(
  parameter int unsigned CHANNELS = flr_pkg::FLR_CHANNELS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic abort,
  input wire flr_pkg::flr_chan_t [CHANNELS-1:0] chan_voltage,
  input wire flr_pkg::flr_chan_t [CHANNELS-1:0] chan_current,
  input wire logic [CHANNELS-1:0] sense_select,
  input wire logic [7:0] head_byte,
  output logic [7:0] head_pos,
  output logic byte_valid,
  input wire logic byte_ready,
  output flr_pkg::flr_beat_t beat,
  output logic busy,
  input wire logic shared_timebase_line_in,
  output logic shared_timebase_line_out,
  output logic shared_timebase_line_oe,
  input wire logic shared_fault_line_in,
  output logic shared_fault_line_out,
  output logic shared_fault_line_oe,
  input wire logic local_fault,
  input wire logic control_line_in,
  output logic peer_fault,
  output logic peer_control,
  output logic peer_tick
);
  import flr_pkg::*;

  localparam int unsigned BEAT_W = $bits(flr_beat_t);
  localparam logic [7:0] TAIL_FIRST = 8'hb0;
  localparam int unsigned TB_DIV = 16;

  typedef struct packed {
    flr_state_t state;
    logic [7:0] pos;
    logic [5:0] loop_byte;
    logic [2:0] chan;
    logic [2:0] slot;
    logic [2:0] fault_sync;
    logic [2:0] ctl_sync;
    logic [2:0] tb_sync;
    logic fault_seen;
    logic ctl_seen;
    logic tb_seen;
    logic tick;
    logic [$clog2(TB_DIV)-1:0] tb_count;
    logic tb_out;
    logic fault_drive;
    logic busy;
    flr_beat_t out_beat;
    logic out_valid;
  } flr_top_state_t;

  flr_top_state_t st;
  flr_top_state_t next_st;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [BEAT_W-1:0] buf_out_data;
  flr_beat_t gen_beat;
  logic gen_valid;
  logic flush;

  // Picks one byte of a channel group; odd channels may carry current instead
  function automatic logic [7:0] chan_byte(input flr_chan_t c, input logic [2:0] s);
    case (s)
      FLR_SLOT_SECONDARY: chan_byte = c.secondary;
      FLR_SLOT_SPECIFIC: chan_byte = c.specific;
      FLR_SLOT_OUTPUT: chan_byte = c.output_status;
      FLR_SLOT_VHIGH: chan_byte = c.reading[15:8];
      default: chan_byte = c.reading[7:0];
    endcase
  endfunction

  // Agreement filter on the last two of three sync stages for pins from outside the clock domain
  function automatic logic settle(input logic [2:0] sy, input logic prev);
    settle = (sy[1] == sy[2]) ? sy[2] : prev;
  endfunction

  assign flush = abort;

  always_comb begin
    logic [7:0] data;
    data = FLR_RESERVED_VALUE;
    gen_beat = '0;
    gen_valid = 1'b0;
    if (st.pos >= FLR_RESERVED_FIRST) begin
      data = FLR_RESERVED_VALUE;
    end else if (st.pos < TAIL_FIRST) begin
      data = head_byte;
    end else if (sense_select[st.chan] && st.chan[0]) begin
      data = chan_byte(chan_current[st.chan], st.slot);
    end else begin
      data = chan_byte(chan_voltage[st.chan], st.slot);
    end
    gen_beat.data = data;
    gen_beat.pos = st.pos;
    gen_beat.invalid = st.pos >= FLR_INVALID_FIRST && st.pos <= FLR_INVALID_LAST;
    gen_beat.last = st.pos == FLR_REC_LAST;
    gen_valid = st.state == FLR_ST_STREAM;
  end

  always_comb begin
    next_st = st;
    // Inverted so a released line matches the reset value; no false fault after reset
    next_st.fault_sync = {st.fault_sync[1:0], !shared_fault_line_in};
    next_st.ctl_sync = {st.ctl_sync[1:0], control_line_in};
    next_st.tb_sync = {st.tb_sync[1:0], shared_timebase_line_in};
    next_st.fault_seen = settle(st.fault_sync, st.fault_seen);
    next_st.ctl_seen = settle(st.ctl_sync, st.ctl_seen);
    next_st.tb_seen = settle(st.tb_sync, st.tb_seen);
    // Rising edge of the agreed shared timebase marks a peer tick
    next_st.tick = next_st.tb_seen && !st.tb_seen;
    next_st.tb_count = st.tb_count + 1'b1;
    if (st.tb_count == '0) begin
      next_st.tb_out = !st.tb_out;
    end
    next_st.fault_drive = local_fault;
    next_st.out_valid = buf_out_valid;
    next_st.out_beat = buf_out_data;
    case (st.state)
      FLR_ST_IDLE: begin
        if (start) begin
          next_st.state = FLR_ST_STREAM;
          next_st.pos = FLR_POS_FIRST;
          next_st.loop_byte = '0;
          next_st.chan = FLR_CHAN_TOP;
          next_st.slot = FLR_SLOT_SECONDARY;
        end
      end
      FLR_ST_STREAM: begin
        if (buf_in_ready) begin
          next_st.pos = st.pos + 8'h01;
          if (st.pos >= TAIL_FIRST) begin
            if (st.slot == FLR_SLOT_VLOW) begin
              next_st.slot = FLR_SLOT_SECONDARY;
              next_st.chan = st.chan - 3'd1;
            end else begin
              next_st.slot = st.slot + 3'd1;
            end
            next_st.loop_byte = (st.loop_byte == FLR_LOOP_LAST) ? '0 : st.loop_byte + 6'd1;
            if (st.loop_byte == FLR_LOOP_LAST) begin
              next_st.chan = FLR_CHAN_TOP;
              next_st.slot = FLR_SLOT_SECONDARY;
            end
          end
          if (st.pos == FLR_REC_LAST) begin
            next_st.state = FLR_ST_DRAIN;
          end
        end
      end
      FLR_ST_DRAIN: begin
        if (!buf_out_valid) begin
          next_st.state = FLR_ST_IDLE;
        end
      end
      default: next_st.state = FLR_ST_IDLE;
    endcase
    if (abort) begin
      next_st.state = FLR_ST_IDLE;
      next_st.pos = FLR_POS_FIRST;
      next_st.out_valid = 1'b0;
    end
    next_st.busy = next_st.state != FLR_ST_IDLE;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Buffer drains whenever byte_ready is high; the output register copies its head every cycle
  flr_skid #(
    .WIDTH(BEAT_W)
  ) u_skid (
    .clk(clk),
    .reset(reset),
    .flush(flush),
    .in_valid(gen_valid),
    .in_ready(buf_in_ready),
    .in_data(gen_beat),
    .out_valid(buf_out_valid),
    .out_ready(byte_ready),
    .out_data(buf_out_data)
  );

  assign head_pos = st.pos;
  assign byte_valid = st.out_valid;
  assign beat = st.out_beat;
  assign busy = st.busy;
  assign shared_timebase_line_out = 1'b0;
  assign shared_timebase_line_oe = !st.tb_out;
  assign shared_fault_line_out = 1'b0;
  assign shared_fault_line_oe = st.fault_drive;
  assign peer_fault = st.fault_seen;
  assign peer_control = st.ctl_seen;
  assign peer_tick = st.tick;
endmodule

// ---- hdl/flr_skid.sv ----
// Two-entry buffer between the record sequencer and the serial-link byte sink.
// Assumes both sides share clk; neither side holds data after a flush.
module flr_skid #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] slot;
    logic [1:0] count;
  } flr_skid_state_t;

  flr_skid_state_t st;
  flr_skid_state_t next_st;
  logic push;
  logic pop;

  always_comb begin
    next_st = st;
    pop = st.count != 2'd0 && out_ready;
    push = in_valid && st.count != 2'd2;
    if (pop) begin
      next_st.slot[0] = st.slot[1];
    end
    if (push) begin
      if (st.count == 2'd0 || (st.count == 2'd1 && pop)) begin
        next_st.slot[0] = in_data;
      end else begin
        next_st.slot[1] = in_data;
      end
    end
    next_st.count = st.count + {1'b0, push} - {1'b0, pop};
    if (flush) begin
      next_st.count = 2'd0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready = st.count != 2'd2;
  assign out_valid = st.count != 2'd0;
  assign out_data = st.slot[0];
endmodule

// ---- tb/flr_host.sv ----
// Host-side sink of the block read: takes bytes, stalling at random when slow.
// Assumes the readout shares its clock and reset.
module flr_host (
  input wire logic clk,
  input wire logic reset,
  input wire logic slow,
  output logic byte_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ready always comes back, so every byte up to 0xfe is clocked out
  always @(posedge clk) byte_ready <= !reset && (!slow || $urandom_range(2) == 0);
endmodule

// ---- tb/flr_readout_chk.sv ----
// Checker of the readout stream framing and the fault line driver.
// Assumes a bind to flr_readout; sees its ports only.
module flr_readout_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic abort,
  input wire logic busy,
  input wire logic byte_valid,
  input wire flr_pkg::flr_beat_t beat,
  input wire logic local_fault,
  input wire logic shared_fault_line_oe
);
  import flr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_last; byte_valid |-> beat.last == (beat.pos == FLR_REC_LAST); endproperty
  a_last: assert property (p_last) else $error("last flag");
  property p_inv;
    byte_valid |-> beat.invalid == (beat.pos inside {[FLR_INVALID_FIRST:FLR_INVALID_LAST]});
  endproperty
  a_inv: assert property (p_inv) else $error("invalid flag");
  property p_zero; byte_valid && beat.pos >= FLR_RESERVED_FIRST |-> beat.data == FLR_RESERVED_VALUE; endproperty
  a_zero: assert property (p_zero) else $error("reserved byte");
  property p_up;
    byte_valid && $past(byte_valid) && beat.pos != $past(beat.pos) |-> beat.pos == $past(beat.pos) + 8'h01;
  endproperty
  a_up: assert property (p_up) else $error("position order");
  property p_first; start && !busy && !abort |-> ##[2:4] (byte_valid && beat.pos == FLR_POS_FIRST); endproperty
  a_first: assert property (p_first) else $error("first byte");
  property p_busy; start && !busy && !abort |=> busy; endproperty
  a_busy: assert property (p_busy) else $error("busy rise");
  property p_flush; abort ##1 !start |-> ##1 !byte_valid; endproperty
  a_flush: assert property (p_flush) else $error("abort flush");
  property p_fault; 1'b1 |=> shared_fault_line_oe == $past(local_fault); endproperty
  a_fault: assert property (p_fault) else $error("fault drive");
  c_last: cover property (byte_valid && beat.last);
  c_abort: cover property (abort && busy);
  c_bad: cover property (byte_valid && beat.invalid);
endmodule
bind flr_readout flr_readout_chk u_chk (.clk(clk), .reset(reset), .start(start), .abort(abort), .busy(busy),
  .byte_valid(byte_valid), .beat(beat), .local_fault(local_fault), .shared_fault_line_oe(shared_fault_line_oe));

// ---- tb/test_fault_log_block_readout.sv ----
// Bench for the fault-log readout: random telemetry, stalls, early ends.
// Assumes flr_host as sink and the bound checker.
module test_fault_log_block_readout;
  timeunit 1ns;
  timeprecision 1ps;
  import flr_pkg::*;
  logic clk = 1'b0, reset = 1'b1, start = 1'b0, abort = 1'b0, slow = 1'b0, local_fault = 1'b0, ctl = 1'b0;
  logic byte_valid, byte_ready, busy, tb_oe, fl_oe, peer_fault, peer_control, peer_tick;
  logic [7:0] sense_select = 8'h00, key = 8'h00, head_pos;
  logic [8:0] e;
  flr_chan_t [7:0] chan_voltage = '0, chan_current = '0;
  flr_beat_t beat;
  int num_errors = 0, n_checks = 0, next_pos = 0, cyc = 0, last_tick = -1;
  always #2.5 clk = ~clk;
  flr_readout uut (.clk, .reset, .start, .abort, .chan_voltage, .chan_current, .sense_select,
    .head_byte(head_pos ^ key), .head_pos, .byte_valid, .byte_ready, .beat, .busy, .local_fault,
    .shared_timebase_line_in(!tb_oe), .shared_timebase_line_out(), .shared_timebase_line_oe(tb_oe),
    .shared_fault_line_in(!fl_oe), .shared_fault_line_out(), .shared_fault_line_oe(fl_oe),
    .control_line_in(ctl), .peer_fault, .peer_control, .peer_tick);
  flr_host host (.clk, .reset, .slow, .byte_ready);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Head, the eight channel groups of each loop and the reserved tail are modelled
  function automatic logic [8:0] exp_byte(input int p);
    int o;
    int ch;
    flr_chan_t t;
    o = (p - 32'hb0) % 46;
    ch = 7 - o / 5;
    if (p < 32'hb0) return {1'b0, 8'(p) ^ key};
    if (p >= 32'hee) return 9'h000;
    if (o >= 40 || p >= 32'he8) return 9'h100; // Loop bytes 40 to 45 and invalid bytes are discarded
    t = (sense_select[ch] && ch % 2 == 1) ? chan_current[ch] : chan_voltage[ch];
    return {1'b0, 8'(t >> (32 - 8 * (o % 5)))};
  endfunction
  // Timebase is toggled every 16 clocks, so peers see one tick per 32
  always @(posedge clk) begin
    cyc++;
    if (!reset && peer_tick === 1'b1) begin
      if (last_tick >= 0) chk(8'(cyc - last_tick), 8'h20);
      last_tick = cyc;
    end
  end
  always @(posedge clk) begin
    if (!reset && byte_valid && beat.pos === 8'(next_pos)) begin
      e = exp_byte(next_pos);
      if (!e[8]) chk(beat.data, e[7:0]);
      next_pos++;
    end
  end
  task automatic wait_pos(input int p);
    for (int n = 0; n < 3000 && next_pos < p; n++) @(posedge clk);
  endtask
  task automatic run_read(input logic stall, input int stop);
    @(posedge clk);
    {key, sense_select, local_fault, ctl} <= 18'($urandom);
    slow <= stall;
    for (int i = 0; i < 8; i++) {chan_voltage[i], chan_current[i]} <= 80'({$urandom, $urandom, $urandom});
    next_pos = 0;
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    wait_pos(stop);
    chk(8'(next_pos >= stop), 8'h01);
    if (stop < 128) abort <= 1'b1;
    else if (stop < 255) start <= 1'b1; // Refused while busy
    @(posedge clk) {start, abort} <= 2'b00;
    if (stop >= 128) begin
      wait_pos(255);
      chk(8'(next_pos), 8'hff);
    end
    for (int n = 0; n < 20 && busy !== 1'b0; n++) @(posedge clk);
    chk(8'(busy), 8'h00);
    repeat (6) @(posedge clk);
    chk(8'(peer_fault), 8'(local_fault));
    chk(8'(peer_control), 8'(ctl));
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #100us;
    num_errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h5c81));
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    run_read(1'b0, 128);
    run_read(1'b1, 1);
    run_read(1'b1, 200);
    run_read(1'b0, 100);
    run_read(1'b0, 255);
    end_of_test();
  end
endmodule
